//--- src/wave_defines.svh
// Purpose: constants of the complementary wave shutdown and dead-band block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: register images are eight bits in the low lanes
`ifndef WAVE_DEFINES_SVH
`define WAVE_DEFINES_SVH
`define ADDR_CONTROL_ONE   12'h000
`define ADDR_CONTROL_TWO   12'h004
`define ADDR_RISING_COUNT  12'h008
`define ADDR_FALLING_COUNT 12'h00c
`define ADDR_IRQ_STATUS    12'h010
`define ADDR_IRQ_MASK      12'h014
`define ADDR_CONTROL_ZERO  12'h018
`define RST_BYTE           8'h00
`define ZERO_COUNT         6'h00
`define COUNT_MASK         8'h3f
`define CTL2_MASK          8'hc3
`define CTL0_MASK          8'h19
`endif

//--- src/wave_pkg.sv
// Purpose: types of the complementary wave shutdown and dead-band block
// Assumes: constants live in wave_defines.svh
// Notes: none
package wave_pkg;
  typedef enum logic [1:0] {
    SD_INACTIVE = 2'h0,
    SD_TRISTATE = 2'h1,
    SD_LOW      = 2'h2,
    SD_HIGH     = 2'h3
  } sd_state_t;
  typedef struct packed {
    logic       drive;
    logic       enable;
  } pin_out_t;
  typedef enum logic {
    PH_LOW,
    PH_HIGH
  } phase_t;
endpackage : wave_pkg

//--- src/complementary_wave_shutdown_deadband.sv
// Purpose: complementary wave outputs with dead band and auto-shutdown, APB slave
// Assumes: REF_CLK 20 MHz, all inputs synchronous to REF_CLK
// Notes: dead band counted in REF_CLK cycles
//
// Behaviour
// - logic cell shutdown enable set: high logic cell output triggers shutdown
// - six-bit rising dead-band count field delays rising output activation
// - nonzero rising code N gives a delay of N to N+1 counts
// - rising code zero bypasses the dead band entirely
// - rising count bits seven and six ignore writes and read zero
`timescale 1ns/1ns
`default_nettype none
`include "wave_defines.svh"
module complementary_wave_shutdown_deadband #(
  parameter int CW = 6
) (
  input  wire logic              REF_CLK,
  input  wire logic              RESETN,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              WAVE_IN,
  input  wire logic              LOGIC_CELL_ONE_OUTPUT,
  input  wire logic              FAULT_INPUT_PIN,
  output wave_pkg::pin_out_t     WAVE_OUTPUT_A,
  output wave_pkg::pin_out_t     WAVE_OUTPUT_B,
  output logic                   IRQ
);
  import wave_pkg::*;

  // ****************************************
  // register bus
  // ****************************************
  logic [7:0]    control_zero_ff;
  logic [7:0]    wave_control_one_ff;
  logic [7:0]    wave_control_two_ff;
  logic [CW-1:0] rising_deadband_count_ff;
  logic [CW-1:0] falling_deadband_count_ff;
  logic [7:0]    irq_status_ff;
  logic [7:0]    irq_mask_ff;
  logic          shutdown_event_flag_ff;
  logic          wr_en;
  logic          rd_ok;
  logic          shutdown_req;
  logic          restart_ok;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction : hit

  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign PREADY  = 1'b1;
  assign rd_ok   = hit(PADDR, `ADDR_CONTROL_ZERO) || hit(PADDR, `ADDR_CONTROL_ONE) ||
                   hit(PADDR, `ADDR_CONTROL_TWO) || hit(PADDR, `ADDR_RISING_COUNT) ||
                   hit(PADDR, `ADDR_FALLING_COUNT) || hit(PADDR, `ADDR_IRQ_STATUS) ||
                   hit(PADDR, `ADDR_IRQ_MASK);
  assign PSLVERR = PSEL && PENABLE && !rd_ok;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      control_zero_ff           <= `RST_BYTE;
      wave_control_one_ff       <= `RST_BYTE;
      rising_deadband_count_ff  <= `ZERO_COUNT;
      falling_deadband_count_ff <= `ZERO_COUNT;
      irq_mask_ff               <= `RST_BYTE;
    end else if (wr_en) begin
      if (hit(PADDR, `ADDR_CONTROL_ZERO)) begin
        control_zero_ff <= PWDATA[7:0] & `CTL0_MASK;
      end
      if (hit(PADDR, `ADDR_CONTROL_ONE)) begin
        wave_control_one_ff <= PWDATA[7:0];
      end
      if (hit(PADDR, `ADDR_RISING_COUNT)) begin
        rising_deadband_count_ff <= PWDATA[CW-1:0];
      end
      if (hit(PADDR, `ADDR_FALLING_COUNT)) begin
        falling_deadband_count_ff <= PWDATA[CW-1:0];
      end
      if (hit(PADDR, `ADDR_IRQ_MASK)) begin
        irq_mask_ff <= {7'h00, PWDATA[0]};
      end
    end
  end

  // shutdown flag: hardware set wins over software clear
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wave_control_two_ff <= `RST_BYTE;
    end else if (wr_en && hit(PADDR, `ADDR_CONTROL_TWO)) begin
      wave_control_two_ff <= PWDATA[7:0] & `CTL2_MASK;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      shutdown_event_flag_ff <= 1'b0;
    end else if (shutdown_req) begin
      shutdown_event_flag_ff <= 1'b1;
    end else if (wr_en && hit(PADDR, `ADDR_CONTROL_TWO)) begin
      shutdown_event_flag_ff <= PWDATA[7];
    end else if (restart_ok) begin
      shutdown_event_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_status_ff <= `RST_BYTE;
    end else if (shutdown_req && !shutdown_event_flag_ff) begin
      irq_status_ff[0] <= 1'b1;
    end else if (wr_en && hit(PADDR, `ADDR_IRQ_STATUS) && PWDATA[0]) begin
      irq_status_ff[0] <= 1'b0;
    end
  end

  assign IRQ = |(irq_status_ff & irq_mask_ff);

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        `ADDR_CONTROL_ZERO:  PRDATA <= {24'h000000, control_zero_ff};
        `ADDR_CONTROL_ONE:   PRDATA <= {24'h000000, wave_control_one_ff};
        `ADDR_CONTROL_TWO:   PRDATA <= {24'h000000, shutdown_event_flag_ff,
                                        wave_control_two_ff[6:0]};
        `ADDR_RISING_COUNT:  PRDATA <= {26'h0000000, rising_deadband_count_ff};
        `ADDR_FALLING_COUNT: PRDATA <= {26'h0000000, falling_deadband_count_ff};
        `ADDR_IRQ_STATUS:    PRDATA <= {24'h000000, irq_status_ff};
        `ADDR_IRQ_MASK:      PRDATA <= {24'h000000, irq_mask_ff};
        default:             PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // shutdown sources
  // ****************************************
  logic gen_enable;
  logic logic_cell_shutdown_enable;
  logic fault_pin_shutdown_enable;
  logic auto_restart_enable;
  logic pol_a;
  logic pol_b;

  assign gen_enable                 = control_zero_ff[0];
  assign pol_a                      = control_zero_ff[3];
  assign pol_b                      = control_zero_ff[4];
  assign logic_cell_shutdown_enable = wave_control_two_ff[1];
  assign fault_pin_shutdown_enable  = wave_control_two_ff[0];
  assign auto_restart_enable        = wave_control_two_ff[6];
  assign shutdown_req = (logic_cell_shutdown_enable && LOGIC_CELL_ONE_OUTPUT) ||
                        (fault_pin_shutdown_enable && !FAULT_INPUT_PIN);
  // auto-restart only once the source is gone, so the outputs never chatter
  assign restart_ok   = auto_restart_enable && !shutdown_req;

  // ****************************************
  // dead band
  // ****************************************
  logic [CW-1:0] db_cnt_ff;
  logic          wave_d_ff;
  logic          act_a_ff;
  logic          act_b_ff;
  logic          edge_seen;
  logic [CW-1:0] cur_count;

  assign edge_seen = WAVE_IN != wave_d_ff;
  assign cur_count = WAVE_IN ? rising_deadband_count_ff : falling_deadband_count_ff;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wave_d_ff <= 1'b0;
    end else begin
      wave_d_ff <= WAVE_IN;
    end
  end

  // counts one extra edge from the input change, giving N to N+1 counts
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      db_cnt_ff <= `ZERO_COUNT;
    end else if (edge_seen) begin
      db_cnt_ff <= cur_count;
    end else if (db_cnt_ff != `ZERO_COUNT) begin
      db_cnt_ff <= db_cnt_ff - 1'b1;
    end
  end

  logic a_now;
  logic b_now;
  // zero code makes the output follow the input combinationally into the flop
  assign a_now = WAVE_IN && (edge_seen ? (cur_count == `ZERO_COUNT)
                                      : (db_cnt_ff <= 6'h01) || act_a_ff);
  assign b_now = !WAVE_IN && (edge_seen ? (cur_count == `ZERO_COUNT)
                                       : (db_cnt_ff <= 6'h01) || act_b_ff);

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      act_a_ff <= 1'b0;
      act_b_ff <= 1'b0;
    end else begin
      act_a_ff <= a_now;
      act_b_ff <= b_now;
    end
  end

  // ****************************************
  // output steering
  // ****************************************
  function automatic pin_out_t steer(input logic active, input logic pol,
                                     input logic [1:0] sel, input logic down);
    pin_out_t p;
    p.drive  = active ^ pol;
    p.enable = 1'b1;
    if (down) begin
      unique case (sd_state_t'(sel))
        SD_INACTIVE: p.drive = pol;
        SD_TRISTATE: begin
          p.drive  = 1'b0;
          p.enable = 1'b0;
        end
        SD_LOW:      p.drive = 1'b0;
        SD_HIGH:     p.drive = 1'b1;
      endcase
    end
    return p;
  endfunction : steer

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      WAVE_OUTPUT_A <= '0;
      WAVE_OUTPUT_B <= '0;
    end else if (!gen_enable) begin
      WAVE_OUTPUT_A <= '0;
      WAVE_OUTPUT_B <= '0;
    end else begin
      WAVE_OUTPUT_A <= steer(act_a_ff, pol_a, wave_control_one_ff[3:2],
                             shutdown_event_flag_ff);
      WAVE_OUTPUT_B <= steer(act_b_ff, pol_b, wave_control_one_ff[5:4],
                             shutdown_event_flag_ff);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_lc_shutdown: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (logic_cell_shutdown_enable && LOGIC_CELL_ONE_OUTPUT) |=> shutdown_event_flag_ff)
    else $error("logic cell shutdown missed");
  a_lc_ignored: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (!shutdown_event_flag_ff && !logic_cell_shutdown_enable
     && !(fault_pin_shutdown_enable && !FAULT_INPUT_PIN)
     && !(wr_en && hit(PADDR, `ADDR_CONTROL_TWO))) |=> !shutdown_event_flag_ff)
    else $error("shutdown without source");
  a_rise_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    ($rose(WAVE_IN) && rising_deadband_count_ff == 6'h02) |=> !act_a_ff [*2])
    else $error("rising output too early");
  a_rise_bound: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    ($rose(WAVE_IN) && rising_deadband_count_ff == 6'h02 && !wr_en) ##1 WAVE_IN[*3]
    |=> act_a_ff)
    else $error("rising output too late");
  a_zero_bypass: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    ($rose(WAVE_IN) && rising_deadband_count_ff == `ZERO_COUNT) |=> act_a_ff)
    else $error("zero code delayed output");
  a_upper_zero: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    $past(PSEL && !PENABLE && hit(PADDR, `ADDR_RISING_COUNT)) |-> PRDATA[7:6] == 2'h0)
    else $error("rising count upper bits nonzero");
  a_sd_low: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (gen_enable && shutdown_event_flag_ff && wave_control_one_ff[3:2] == 2'h2)
    |=> (WAVE_OUTPUT_A.drive == 1'b0))
    else $error("output a not forced low");
  a_sd_tri: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (gen_enable && shutdown_event_flag_ff && wave_control_one_ff[5:4] == 2'h1)
    |=> !WAVE_OUTPUT_B.enable)
    else $error("output b not tri-stated");
  a_sd_high: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (gen_enable && shutdown_event_flag_ff && wave_control_one_ff[3:2] == 2'h3)
    |=> (WAVE_OUTPUT_A.drive && WAVE_OUTPUT_A.enable))
    else $error("output a not forced high");
  a_sd_idle: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (gen_enable && shutdown_event_flag_ff && wave_control_one_ff[3:2] == 2'h0)
    |=> (WAVE_OUTPUT_A.drive == $past(pol_a)))
    else $error("output a not at inactive level");
  a_no_overlap: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (gen_enable && !shutdown_event_flag_ff && !pol_a && !pol_b)
    |=> !(WAVE_OUTPUT_A.drive && WAVE_OUTPUT_B.drive))
    else $error("outputs overlap");
  c_shutdown: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    $rose(shutdown_event_flag_ff));
  c_restart: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    $fell(shutdown_event_flag_ff) && auto_restart_enable);
  c_rise_delay: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    $rose(WAVE_IN) && rising_deadband_count_ff != `ZERO_COUNT ##[1:70] act_a_ff);
  c_irq: cover property (@(posedge REF_CLK) disable iff (!RESETN) $rose(IRQ));
  c_tristate: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    gen_enable && shutdown_event_flag_ff && !WAVE_OUTPUT_B.enable);
endmodule : complementary_wave_shutdown_deadband
`default_nettype wire

//--- tb/power_stage_model.sv
// Purpose: half-bridge stage driven by the two wave outputs
// Assumes: a pull-down on each gate line
// Notes: a released gate reads its pull level, never the last drive
`timescale 1ns/1ns
`default_nettype none
module power_stage_model (
  input  wire wave_pkg::pin_out_t gate_a,
  input  wire wave_pkg::pin_out_t gate_b,
  output logic                    high_side,
  output logic                    low_side,
  output logic                    shoot
);
  import wave_pkg::*;
  assign high_side = gate_a.enable ? gate_a.drive : 1'b0;
  assign low_side  = gate_b.enable ? gate_b.drive : 1'b0;
  // both switches on would short the supply
  assign shoot     = high_side & low_side;
endmodule : power_stage_model
`default_nettype wire

//--- tb/test_complementary_wave_shutdown_deadband.sv
// Purpose: self-checking bench of the wave shutdown and dead-band block
// Assumes: zero-wait APB slave, polarity zero but for one shutdown case
// Notes: outputs are sampled at the edge, so one extra count shows
`timescale 1ns/1ns
`default_nettype none
`include "wave_defines.svh"
module test_complementary_wave_shutdown_deadband;
  import wave_pkg::*;
  logic        ref_clk = 0;
  logic        resetn  = 0;
  logic        psel    = 0;
  logic        penable = 0;
  logic        pwrite  = 0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wave_in = 0;
  logic        lc_out  = 0;
  logic        fault_n = 1;
  pin_out_t    out_a;
  pin_out_t    out_b;
  logic        irq;
  logic        hs;
  logic        ls;
  logic        shoot;
  int          errors  = 0;
  int          compares = 0;
  always #25 ref_clk = ~ref_clk;
  complementary_wave_shutdown_deadband dut (.REF_CLK(ref_clk), .RESETN(resetn),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .WAVE_IN(wave_in),
    .LOGIC_CELL_ONE_OUTPUT(lc_out), .FAULT_INPUT_PIN(fault_n),
    .WAVE_OUTPUT_A(out_a), .WAVE_OUTPUT_B(out_b), .IRQ(irq));
  power_stage_model stage (.gate_a(out_a), .gate_b(out_b), .high_side(hs),
    .low_side(ls), .shoot(shoot));
  // ********************
  // shared tasks
  // ********************
  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      test_done();
    end
    @(posedge ref_clk);
  endtask : apb
  // ********************
  // scenarios
  // ********************
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    apb(1, `ADDR_RISING_COUNT, 32'hffff_ffff, q, e);
    apb(0, `ADDR_RISING_COUNT, 32'h0, q, e);
    check(q, 32'h3f);
    apb(0, 12'h01c, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    $display("done registers");
  endtask : t_regs
  task automatic t_deadband(input logic [5:0] code);
    logic [31:0] q;
    logic        e;
    int          n;
    apb(1, `ADDR_RISING_COUNT, {26'h0, code}, q, e);
    wave_in <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (out_a.drive !== 1'b1 && n < 80);
    if (out_a.drive !== 1'b1) begin
      errors++;
      test_done();
    end
    if (code == 6'h00) check(n, 3);
    else check(n >= code + 3 && n <= code + 4, 1);
    check(shoot, 0);
    wave_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check(out_a.drive, 0);
    $display("done dead band code %0d", code);
  endtask : t_deadband
  task automatic t_shutdown(input logic lc, input logic [7:0] ctl1,
                            input pin_out_t ea, input pin_out_t eb, input logic m);
    logic [31:0] q;
    logic        e;
    apb(1, `ADDR_IRQ_MASK, {31'h0, m}, q, e);
    apb(1, `ADDR_CONTROL_ONE, {24'h0, ctl1}, q, e);
    apb(1, `ADDR_CONTROL_TWO, {30'h0, lc, ~lc}, q, e);
    if (lc) lc_out <= 1'b1;
    else fault_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(out_a, ea);
    check(out_b & (eb.enable ? 2'b11 : 2'b01), eb);
    check(irq, m);
    apb(0, `ADDR_CONTROL_TWO, 32'h0, q, e);
    check(q, {24'h0, 1'b1, 5'h0, lc, ~lc});
    lc_out <= 1'b0;
    fault_n <= 1'b1;
    @(posedge ref_clk);
    apb(1, `ADDR_IRQ_STATUS, 32'h1, q, e);
    apb(1, `ADDR_CONTROL_TWO, 32'h0, q, e);
    check(irq, 0);
    $display("done shutdown %0d", lc);
  endtask : t_shutdown
  task automatic t_lc_off;
    logic [31:0] q;
    logic        e;
    apb(1, `ADDR_CONTROL_TWO, 32'h1, q, e);
    lc_out <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(0, `ADDR_CONTROL_TWO, 32'h0, q, e);
    check(q, 32'h1);
    lc_out <= 1'b0;
    $display("done logic cell disabled");
  endtask : t_lc_off
  task automatic t_restart;
    logic [31:0] q;
    logic        e;
    apb(1, `ADDR_CONTROL_TWO, 32'h42, q, e);
    lc_out <= 1'b1;
    repeat (2) @(posedge ref_clk);
    apb(0, `ADDR_CONTROL_TWO, 32'h0, q, e);
    check(q, 32'hc2);
    lc_out <= 1'b0;
    repeat (2) @(posedge ref_clk);
    apb(0, `ADDR_CONTROL_TWO, 32'h0, q, e);
    check(q, 32'h42);
    apb(1, `ADDR_IRQ_STATUS, 32'h1, q, e);
    apb(1, `ADDR_CONTROL_TWO, 32'h0, q, e);
    $display("done auto restart");
  endtask : t_restart
  initial begin
    logic [31:0] q;
    logic        e;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    apb(1, `ADDR_CONTROL_ZERO, 32'h1, q, e);
    t_deadband(6'h00);
    t_deadband(6'h01);
    t_deadband(6'h02);
    t_deadband(6'h3f);
    t_shutdown(1'b1, 8'h1c, '{drive: 1'b1, enable: 1'b1}, '{drive: 1'b0, enable: 1'b0}, 1'b1);
    t_shutdown(1'b0, 8'h08, '{drive: 1'b0, enable: 1'b1}, '{drive: 1'b0, enable: 1'b1}, 1'b0);
    apb(1, `ADDR_CONTROL_ZERO, 32'h19, q, e);
    t_shutdown(1'b1, 8'h20, '{drive: 1'b1, enable: 1'b1}, '{drive: 1'b0, enable: 1'b1}, 1'b0);
    apb(1, `ADDR_CONTROL_ZERO, 32'h1, q, e);
    t_lc_off();
    t_restart();
    test_done();
  end
endmodule : test_complementary_wave_shutdown_deadband
`default_nettype wire
